// File: src/pmcwl_loader.sv
// Loads power management words for ports 0 to 3 from the configuration memory
`include "pmcwl_cfg.svh"
`default_nettype none
// Summary of operation
// - Bit 0 of the capability word at 52h, 54h or 56h becomes the no-soft-reset bit of port 1, 2 or 3.
// - Capability word bits 3 to 1 become the port's auxiliary current field.
// - The D1 support flag always reads as 1 whatever word bit 4 holds.
// - The D2 support flag always reads as 1 whatever word bit 5 holds.
// - Capability word bits 7 to 6 become the PME support bits for D2 and D1.
// - Data word bits 15 to 8 become the port's read-only power management data byte.
// - Data words for ports 0 to 3 are fetched from addresses 51h, 53h, 55h and 57h.
// - Port 0's capability word is fetched from 50h with the same layout as the others.
module pmcwl_loader (
    input  wire logic        sys_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        mem_present_in,
    input  wire logic        mem_ack_in,
    input  wire logic [15:0] mem_data_in,
    output var  logic        mem_req_out,
    output var  logic [7:0]  mem_addr_out,
    output var  logic        load_done_out,
    output var  logic [3:0]  nsr_out,
    output var  logic [11:0] aux_cur_out,
    output var  logic [3:0]  d1_sup_out,
    output var  logic [3:0]  d2_sup_out,
    output var  logic [7:0]  pme_sup_out,
    output var  logic [31:0] pm_data_out
);
    pmcwl_pkg::pmcwl_ctl_t c_q;
    pmcwl_pkg::pmcwl_ctl_t c_d;

    logic       take;
    logic [1:0] port_sel;
    logic       is_data;
    logic [3:0] cap_wr;
    logic [3:0] data_wr;
    logic       publish;

    // A word is taken only on an acknowledge while the request stands
    // An acknowledge with no request standing is dropped here, never counted
    assign take     = mem_ack_in && c_q.req && (c_q.state == pmcwl_pkg::PMCWL_ST_REQ);
    assign port_sel = c_q.addr[2:1];
    assign is_data  = c_q.addr[0];
    assign publish  = (c_q.state == pmcwl_pkg::PMCWL_ST_PUB);

    // Even address is a capability word, odd address a data word
    // Address bits 2:1 pick the port, bit 0 the kind of word
    always_comb begin
        cap_wr  = 4'h0;
        data_wr = 4'h0;
        if (take && !is_data) begin
            cap_wr[port_sel] = 1'b1;
        end
        if (take && is_data) begin
            data_wr[port_sel] = 1'b1;
        end
    end

    // Sequencer: walk 50h..57h in order, then publish once.
    // Request and address stand unchanged until the edge that sees the
    // acknowledge; that same edge captures the word.
    // Acknowledges may come back to back, so a full load takes ten edges at best.
    // No timeout: a missing memory must be flagged on mem_present_in,
    // otherwise the walk waits and the defaults simply stay visible.
    always_comb begin
        c_d = c_q;
        case (c_q.state)
            pmcwl_pkg::PMCWL_ST_START: begin
                if (mem_present_in) begin
                    c_d.state = pmcwl_pkg::PMCWL_ST_REQ;
                    c_d.addr  = `PMCWL_ADDR_FIRST;
                    c_d.req   = 1'b1;
                end else begin
                    // No memory: publish the untouched defaults
                    c_d.state = pmcwl_pkg::PMCWL_ST_PUB;
                end
            end
            pmcwl_pkg::PMCWL_ST_REQ: begin
                // Hold request and address until the word is taken
                if (take) begin
                    if (c_q.addr == `PMCWL_ADDR_LAST) begin
                        c_d.state = pmcwl_pkg::PMCWL_ST_PUB;
                        c_d.req   = 1'b0;
                    end else begin
                        c_d.addr = c_q.addr + 8'h01;
                    end
                end
            end
            pmcwl_pkg::PMCWL_ST_PUB: begin
                // Shadows copy to the visible fields on this edge
                c_d.state = pmcwl_pkg::PMCWL_ST_DONE;
                c_d.done  = 1'b1;
            end
            pmcwl_pkg::PMCWL_ST_DONE: begin
                // Stay here until the next reset
                c_d.req = 1'b0;
            end
            default: begin
                c_d.state = pmcwl_pkg::PMCWL_ST_START;
                c_d.req   = 1'b0;
            end
        endcase
    end

    // Control register; a synchronous reset restarts the walk at 50h
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            c_q <= '{state: pmcwl_pkg::PMCWL_ST_START, addr: `PMCWL_ADDR_FIRST, req: 1'b0, done: 1'b0};
        end else begin
            c_q <= c_d;
        end
    end

    // Handshake and finish flag come straight from the control register
    assign mem_req_out   = c_q.req;
    assign mem_addr_out  = c_q.addr;
    assign load_done_out = c_q.done;

    // One field set per port; the same layout serves all four.
    // Shared publish keeps the ports in step: no mix of old and new fields.
    genvar p;
    generate
        for (p = 0; p < 4; p++) begin : g_port
            pmcwl_port_fields u_fields (
                .sys_clk_in  (sys_clk_in),
                .sys_rst_in  (sys_rst_in),
                .cap_wr_in   (cap_wr[p]),
                .data_wr_in  (data_wr[p]),
                .publish_in  (publish),
                .word_in     (mem_data_in),
                .nsr_out     (nsr_out[p]),
                .aux_cur_out (aux_cur_out[3*p +: 3]),
                .d1_sup_out  (d1_sup_out[p]),
                .d2_sup_out  (d2_sup_out[p]),
                .pme_sup_out (pme_sup_out[2*p +: 2]),
                .pm_data_out (pm_data_out[8*p +: 8])
            );
        end
    endgenerate

    // Checks on the sequencer
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);

    // Word routing: every address lands in exactly one shadow of one port
    a_p0_cap_addr: assert property (take && c_q.addr == `PMCWL_ADDR_P0_CAP |-> cap_wr == 4'h1)
        else $error("word at 50h not routed to port 0 capability");
    a_p1_cap_addr: assert property (take && c_q.addr == `PMCWL_ADDR_P1_CAP |-> cap_wr == 4'h2)
        else $error("word at 52h not routed to port 1 capability");
    a_p2_cap_addr: assert property (take && c_q.addr == `PMCWL_ADDR_P2_CAP |-> cap_wr == 4'h4)
        else $error("word at 54h not routed to port 2 capability");
    a_p3_cap_addr: assert property (take && c_q.addr == `PMCWL_ADDR_P3_CAP |-> cap_wr == 4'h8)
        else $error("word at 56h not routed to port 3 capability");
    a_p0_data_addr: assert property (take && c_q.addr == `PMCWL_ADDR_P0_DATA |-> data_wr == 4'h1)
        else $error("word at 51h not routed to port 0 data");
    a_p1_data_addr: assert property (take && c_q.addr == `PMCWL_ADDR_P1_DATA |-> data_wr == 4'h2)
        else $error("word at 53h not routed to port 1 data");
    a_p2_data_addr: assert property (take && c_q.addr == `PMCWL_ADDR_P2_DATA |-> data_wr == 4'h4)
        else $error("word at 55h not routed to port 2 data");
    a_p3_data_addr: assert property (take && c_q.addr == `PMCWL_ADDR_P3_DATA |-> data_wr == 4'h8)
        else $error("word at 57h not routed to port 3 data");
    a_one_target: assert property ($onehot0({cap_wr, data_wr}))
        else $error("one word routed to more than one field set");
    a_idle_no_write: assert property (!mem_req_out |-> cap_wr == 4'h0 && data_wr == 4'h0)
        else $error("acknowledge taken while no request stood");

    // Walk order, and the request standing while the memory is slow
    a_first_addr: assert property ($rose(mem_req_out) |-> mem_addr_out == `PMCWL_ADDR_P0_CAP)
        else $error("load did not start at 50h");
    a_req_after_start: assert property (!sys_rst_in && c_q.state == pmcwl_pkg::PMCWL_ST_START
                                        && mem_present_in |=> mem_req_out && mem_addr_out == `PMCWL_ADDR_FIRST)
        else $error("request not raised at 50h after reset");
    a_addr_step: assert property (take && c_q.addr != `PMCWL_ADDR_LAST
                                  |=> mem_addr_out == $past(mem_addr_out) + 8'h01 && mem_req_out)
        else $error("address did not advance after a word");
    a_req_hold: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
        else $error("request or address moved before the acknowledge");
    a_addr_range: assert property (mem_req_out |-> mem_addr_out >= `PMCWL_ADDR_FIRST
                                   && mem_addr_out <= `PMCWL_ADDR_LAST)
        else $error("request outside the 50h to 57h window");

    // Finish: publish once, then the fields freeze until the next reset.
    // Sampled reset in the antecedents: the release edge must not open an attempt.
    a_done_after_last: assert property (take && c_q.addr == `PMCWL_ADDR_LAST
                                        |=> !mem_req_out ##1 load_done_out)
        else $error("load not finished two cycles after the last word");
    a_no_mem_default: assert property (!sys_rst_in && c_q.state == pmcwl_pkg::PMCWL_ST_START
                                       && !mem_present_in
                                       |=> ##1 (load_done_out && pm_data_out == 32'h00000000 && nsr_out == 4'h0
                                       && aux_cur_out == 12'h000 && pme_sup_out == 8'h00))
        else $error("defaults not kept without configuration memory");
    a_no_mem_no_req: assert property (!sys_rst_in && c_q.state == pmcwl_pkg::PMCWL_ST_START
                                      && !mem_present_in |=> !mem_req_out [*2])
        else $error("request raised with no configuration memory");
    a_hidden_early: assert property (!load_done_out && !publish |=> nsr_out == 4'h0 && pme_sup_out == 8'h00)
        else $error("fields visible before load finished");
    a_hidden_data: assert property (!load_done_out && !publish |=> pm_data_out == 32'h00000000
                                    && aux_cur_out == 12'h000)
        else $error("data or aux fields visible before load finished");
    a_publish_once: assert property (publish |=> !publish)
        else $error("publish lasted more than one cycle");
    a_publish_first: assert property ($rose(load_done_out) |-> $past(publish))
        else $error("load finished without a publish cycle");
    a_done_sticky: assert property (load_done_out |=> load_done_out && !mem_req_out)
        else $error("load finished flag dropped or request raised again");
    a_fields_frozen: assert property (load_done_out |=> $stable(nsr_out) && $stable(aux_cur_out)
                                      && $stable(pme_sup_out) && $stable(pm_data_out))
        else $error("visible fields changed after the load finished");

    // Support flags are fixed, whatever the words carry
    a_d1_all_ports: assert property (d1_sup_out == 4'hf)
        else $error("D1 support flag clear on some port");
    a_d2_all_ports: assert property (d2_sup_out == 4'hf)
        else $error("D2 support flag clear on some port");

    // Scenarios worth seeing in a run
    c_full_load: cover property (take && c_q.addr == `PMCWL_ADDR_LAST ##2 load_done_out);
    c_no_memory: cover property (!sys_rst_in && c_q.state == pmcwl_pkg::PMCWL_ST_START && !mem_present_in
                                 ##2 load_done_out);
    c_stalled: cover property (mem_req_out && !mem_ack_in [*3] ##1 take);
    c_back_to_back: cover property (take ##1 take);
    c_slow_word: cover property ((mem_req_out && !mem_ack_in) [*6] ##1 take);
endmodule
`default_nettype wire

// File: include/pmcwl_cfg.svh
// Addresses, field positions, reset values and fixed values for the power management word loader
`ifndef PMCWL_CFG_SVH
`define PMCWL_CFG_SVH

// Configuration memory word addresses
`define PMCWL_ADDR_FIRST    8'h50
`define PMCWL_ADDR_LAST     8'h57
`define PMCWL_ADDR_P0_CAP   8'h50
`define PMCWL_ADDR_P0_DATA  8'h51
`define PMCWL_ADDR_P1_CAP   8'h52
`define PMCWL_ADDR_P1_DATA  8'h53
`define PMCWL_ADDR_P2_CAP   8'h54
`define PMCWL_ADDR_P2_DATA  8'h55
`define PMCWL_ADDR_P3_CAP   8'h56
`define PMCWL_ADDR_P3_DATA  8'h57

// Bit positions inside a capability word
`define PMCWL_W_NSR         0
`define PMCWL_W_AUX_HI      3
`define PMCWL_W_AUX_LO      1
`define PMCWL_W_PME_HI      7
`define PMCWL_W_PME_LO      6

// Bit positions inside a data word
`define PMCWL_W_DATA_HI     15
`define PMCWL_W_DATA_LO     8

// Field values before any load, or with no memory fitted
`define PMCWL_RST_NSR       1'h0
`define PMCWL_RST_AUX       3'h0
`define PMCWL_RST_PME       2'h0
`define PMCWL_RST_DATA      8'h00
`define PMCWL_D1_SUP        1'h1
`define PMCWL_D2_SUP        1'h1

`endif

// File: include/pmcwl_pkg.sv
// Types shared by the power management word loader
`default_nettype none
package pmcwl_pkg;

    typedef enum logic [1:0] {
        PMCWL_ST_START,
        PMCWL_ST_REQ,
        PMCWL_ST_PUB,
        PMCWL_ST_DONE
    } pmcwl_state_t;

    typedef struct packed {
        pmcwl_state_t state;
        logic [7:0]   addr;
        logic         req;
        logic         done;
    } pmcwl_ctl_t;

    typedef struct packed {
        logic       sh_nsr;
        logic [2:0] sh_aux;
        logic [1:0] sh_pme;
        logic [7:0] sh_data;
        logic       nsr;
        logic [2:0] aux;
        logic       d1;
        logic       d2;
        logic [1:0] pme;
        logic [7:0] data;
    } pmcwl_fields_t;

endpackage
`default_nettype wire

// File: src/pmcwl_port_fields.sv
// Per-port shadow and visible power management fields
`include "pmcwl_cfg.svh"
`default_nettype none
module pmcwl_port_fields (
    input  wire logic        sys_clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        cap_wr_in,
    input  wire logic        data_wr_in,
    input  wire logic        publish_in,
    input  wire logic [15:0] word_in,
    output var  logic        nsr_out,
    output var  logic [2:0]  aux_cur_out,
    output var  logic        d1_sup_out,
    output var  logic        d2_sup_out,
    output var  logic [1:0]  pme_sup_out,
    output var  logic [7:0]  pm_data_out
);
    pmcwl_pkg::pmcwl_fields_t f_q;
    pmcwl_pkg::pmcwl_fields_t f_d;

    // Words land in a shadow first so reads never see a half-loaded set
    always_comb begin
        f_d = f_q;
        if (cap_wr_in) begin
            f_d.sh_nsr = word_in[`PMCWL_W_NSR];
            f_d.sh_aux = word_in[`PMCWL_W_AUX_HI:`PMCWL_W_AUX_LO];
            f_d.sh_pme = word_in[`PMCWL_W_PME_HI:`PMCWL_W_PME_LO];
        end
        if (data_wr_in) begin
            f_d.sh_data = word_in[`PMCWL_W_DATA_HI:`PMCWL_W_DATA_LO];
        end
        // Publish copies the shadow in one edge
        if (publish_in) begin
            f_d.nsr  = f_q.sh_nsr;
            f_d.aux  = f_q.sh_aux;
            f_d.pme  = f_q.sh_pme;
            f_d.data = f_q.sh_data;
        end
        // Support flags ignore the word bits and stay set
        f_d.d1 = `PMCWL_D1_SUP;
        f_d.d2 = `PMCWL_D2_SUP;
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            f_q <= '{sh_nsr: `PMCWL_RST_NSR, sh_aux: `PMCWL_RST_AUX, sh_pme: `PMCWL_RST_PME,
                     sh_data: `PMCWL_RST_DATA, nsr: `PMCWL_RST_NSR, aux: `PMCWL_RST_AUX,
                     d1: `PMCWL_D1_SUP, d2: `PMCWL_D2_SUP, pme: `PMCWL_RST_PME,
                     data: `PMCWL_RST_DATA};
        end else begin
            f_q <= f_d;
        end
    end

    // Data byte has no write path from software: outputs only
    assign nsr_out     = f_q.nsr;
    assign aux_cur_out = f_q.aux;
    assign d1_sup_out  = f_q.d1;
    assign d2_sup_out  = f_q.d2;
    assign pme_sup_out = f_q.pme;
    assign pm_data_out = f_q.data;

    // Helper copies of the last words written, for the checks below
    logic [15:0] last_cap_q;
    logic [15:0] last_data_q;
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            last_cap_q  <= 16'h0000;
            last_data_q <= 16'h0000;
        end else begin
            if (cap_wr_in) begin
                last_cap_q <= word_in;
            end
            if (data_wr_in) begin
                last_data_q <= word_in;
            end
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);

    a_nsr_copy: assert property (publish_in && !cap_wr_in |=> nsr_out == last_cap_q[`PMCWL_W_NSR])
        else $error("no soft reset bit not taken from capability word");
    a_aux_copy: assert property (publish_in && !cap_wr_in |=> aux_cur_out == last_cap_q[3:1])
        else $error("aux current field not taken from word bits 3 to 1");
    a_d1_fixed: assert property (##1 d1_sup_out)
        else $error("D1 support flag not set");
    a_d2_fixed: assert property (cap_wr_in |=> d2_sup_out [*2])
        else $error("D2 support flag not set");
    a_pme_copy: assert property (publish_in && !cap_wr_in |=> pme_sup_out == last_cap_q[7:6])
        else $error("PME support bits not taken from word bits 7 to 6");
    a_data_copy: assert property (publish_in && !data_wr_in |=> pm_data_out == last_data_q[15:8])
        else $error("data byte not taken from word bits 15 to 8");
    a_data_hold: assert property (!publish_in |=> $stable(pm_data_out))
        else $error("visible data byte changed without publish");
endmodule
`default_nettype wire

// File: verif/pmcwl_mem_model.sv
// Behavioural configuration memory answering word reads after a programmable delay
`default_nettype none
module pmcwl_mem_model (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic         req_in,
    input  wire logic [7:0]   addr_in,
    input  wire logic [127:0] words_in,
    input  wire logic [3:0]   lat_in,
    output var  logic         ack_out,
    output var  logic [15:0]  data_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0]  wait_q;
    logic [15:0] last_q;

    // Delay restarts after every answer, so each word sees the full latency
    always @(posedge clk_in) begin
        if (rst_in || !req_in || ack_out) begin
            wait_q <= 4'h0;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
        if (rst_in) begin
            last_q <= 16'h0000;
        end else if (ack_out) begin
            last_q <= data_out;
        end
    end

    // Data is only valid with ack; otherwise the inverse of the last word, never a stale copy
    always_comb begin
        ack_out  = req_in && (wait_q == lat_in);
        data_out = ack_out ? words_in[16 * addr_in[2:0] +: 16] : ~last_q;
    end
endmodule
`default_nettype wire

// File: verif/pmcwl_loader_bench.sv
// Self-checking bench for the power management word loader
`default_nettype none
module pmcwl_loader_bench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [3:0]  nsr;
        logic [11:0] aux;
        logic [7:0]  pme;
        logic [31:0] data;
        logic [7:0]  nwords;
    } pmcwl_exp_t;

    logic         sys_clk_in;
    logic         sys_rst_in;
    logic         mem_present_in;
    logic         mem_ack_in;
    logic [15:0]  mem_data_in;
    logic         mem_req_out;
    logic [7:0]   mem_addr_out;
    logic         load_done_out;
    logic [3:0]   nsr_out;
    logic [11:0]  aux_cur_out;
    logic [3:0]   d1_sup_out;
    logic [3:0]   d2_sup_out;
    logic [7:0]   pme_sup_out;
    logic [31:0]  pm_data_out;
    logic [127:0] words;
    logic [127:0] w_rand;
    logic [3:0]   lat_q;
    logic [7:0]   k;
    logic         seen;
    pmcwl_exp_t   q[$];
    pmcwl_exp_t   e;
    integer       seed;
    int           n_mismatch;
    int           cmp_count;

    pmcwl_loader uut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .mem_present_in(mem_present_in),
        .mem_ack_in(mem_ack_in), .mem_data_in(mem_data_in), .mem_req_out(mem_req_out),
        .mem_addr_out(mem_addr_out), .load_done_out(load_done_out), .nsr_out(nsr_out),
        .aux_cur_out(aux_cur_out), .d1_sup_out(d1_sup_out), .d2_sup_out(d2_sup_out),
        .pme_sup_out(pme_sup_out), .pm_data_out(pm_data_out));

    pmcwl_mem_model mem (.clk_in(sys_clk_in), .rst_in(sys_rst_in), .req_in(mem_req_out),
        .addr_in(mem_addr_out), .words_in(words), .lat_in(lat_q), .ack_out(mem_ack_in),
        .data_out(mem_data_in));

    // Free-running 250 MHz clock
    always #2 sys_clk_in = ~sys_clk_in;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Even slot 2p is port p's capability word, odd slot 2p+1 its data word
    function automatic pmcwl_exp_t expect_of(input logic [127:0] w, input logic present);
        pmcwl_exp_t r;
        r = '0;
        r.nwords = present ? 8'h08 : 8'h00;
        for (int p = 0; p < 4; p++) begin
            if (present) begin
                r.nsr[p]         = w[32 * p];
                r.aux[3 * p +: 3] = w[32 * p + 1 +: 3];
                r.pme[2 * p +: 2] = w[32 * p + 6 +: 2];
                r.data[8 * p +: 8] = w[32 * p + 24 +: 8];
            end
        end
        return r;
    endfunction

    // Reset, check reset values, then load; a nonzero abort_at cuts the load short
    task automatic run_load(input string name, input logic [127:0] w, input logic [3:0] lat,
                            input logic present, input int abort_at);
        int n;
        sys_rst_in     <= 1'b1;
        words          <= w;
        lat_q          <= lat;
        mem_present_in <= present;
        repeat (4) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        check("mem_req_out", 32'h0, 32'(mem_req_out));
        check("mem_addr_out", 32'h50, 32'(mem_addr_out));
        check("load_done_out", 32'h0, 32'(load_done_out));
        check("d1_sup_out", 32'hf, 32'(d1_sup_out));
        check("pm_data_out", 32'h0, pm_data_out);
        @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        if (abort_at > 0) begin
            repeat (abort_at) @(posedge sys_clk_in);
        end else begin
            q.push_back(expect_of(w, present));
            n = 0;
            while (load_done_out !== 1'b1 && n < 200) begin
                @(negedge sys_clk_in);
                n++;
            end
            if (load_done_out !== 1'b1) begin
                $display("wrong value load_done_out expected 1 seen %b", load_done_out);
                n_mismatch++;
                summarize();
            end
            repeat (2) @(posedge sys_clk_in);
        end
        $display("test %s done", name);
    endtask

    // Watcher: address order at each taken word, fields against the oldest note when done rises
    always @(negedge sys_clk_in) begin
        if (sys_rst_in) begin
            seen = 1'b0;
            k    = 8'h00;
        end else begin
            if (mem_req_out === 1'b1 && mem_ack_in === 1'b1) begin
                check("mem_addr_out", 32'(8'h50 + k), 32'(mem_addr_out));
                check("pm_data_out early", 32'h0, pm_data_out);
                check("nsr_out early", 32'h0, 32'(nsr_out));
                k = k + 8'h01;
            end
            if (load_done_out === 1'b1 && !seen) begin
                seen = 1'b1;
                if (q.size() == 0) begin
                    $display("wrong value load_done_out expected 0 seen 1");
                    n_mismatch++;
                end else begin
                    e = q.pop_front();
                    check("word count", 32'(e.nwords), 32'(k));
                    check("nsr_out", 32'(e.nsr), 32'(nsr_out));
                    check("aux_cur_out", 32'(e.aux), 32'(aux_cur_out));
                    check("d1_sup_out", 32'hf, 32'(d1_sup_out));
                    check("d2_sup_out", 32'hf, 32'(d2_sup_out));
                    check("pme_sup_out", 32'(e.pme), 32'(pme_sup_out));
                    check("pm_data_out", e.data, pm_data_out);
                end
            end
        end
    end

    // Main sequence: random words at several latencies, edge patterns, no memory, reset mid-load
    initial begin
        sys_clk_in     = 1'b0;
        sys_rst_in     = 1'b1;
        mem_present_in = 1'b0;
        words          = '0;
        lat_q          = 4'h0;
        seed           = 32'ha5250ea1;
        n_mismatch     = 0;
        cmp_count      = 0;
        repeat (4) @(posedge sys_clk_in);
        for (int i = 0; i < 4; i++) begin
            w_rand = {$random(seed), $random(seed), $random(seed), $random(seed)};
            run_load("random", w_rand, 4'(2 * i), 1'b1, 0);
        end
        run_load("all zero", 128'h0, 4'h1, 1'b1, 0);
        run_load("all ones", {8{16'hffff}}, 4'h0, 1'b1, 0);
        run_load("no memory", {8{16'hffff}}, 4'h0, 1'b0, 0);
        run_load("abort", w_rand, 4'h3, 1'b1, 12);
        run_load("after abort", ~w_rand, 4'h0, 1'b1, 0);
        if (q.size() != 0) begin
            $display("wrong value pending loads expected 0 seen %0d", q.size());
            n_mismatch++;
        end
        summarize();
    end
endmodule
`default_nettype wire
